// ===== logic/spd_pkg.sv
/*
  Shared constants of the short-window power detector: register indices,
  field positions, reset values and the PA clock period factors.
  Assumes an AXI4-Lite register bus with one 32-bit word per register.
*/
package spd_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_PAGE_SELECT      = 12'h008;
  localparam logic [11:0] IDX_RAMP_CONTROL     = 12'h581;
  localparam logic [11:0] IDX_LONG_POWER_HIGH  = 12'h587;
  localparam logic [11:0] IDX_SHORT_THR_LOW    = 12'h588;
  localparam logic [11:0] IDX_SHORT_THR_HIGH   = 12'h589;
  localparam logic [11:0] IDX_SHORT_CONTROL    = 12'h58A;
  localparam logic [11:0] IDX_SHORT_POWER_LOW  = 12'h58B;
  localparam logic [11:0] IDX_SHORT_POWER_HIGH = 12'h58C;
  localparam logic [11:0] IDX_TX_FSM_CONTROL   = 12'h58D;
  localparam logic [11:0] IDX_IRQ_STATUS       = 12'h5A0;
  localparam logic [11:0] IDX_IRQ_CLEAR        = 12'h5A1;
  localparam logic [11:0] IDX_IRQ_ENABLE       = 12'h5A2;

  // field positions
  localparam int POS_DETECT_ON   = 7;
  localparam int POS_RAMP_ON     = 7;
  localparam int POS_FSM_ON      = 0;
  localparam int HIGH_FIELD_BITS = 5;
  localparam int SAMPLE_MSBS     = 6;
  localparam int POWER_BITS      = 13;

  // values after reset
  localparam logic [1:0]  RST_PAGE_SELECT = 2'h1;
  localparam logic        RST_RAMP_ON     = 1'b1;
  localparam logic [12:0] RST_THRESHOLD   = 13'h0000;
  localparam logic        RST_DETECT_ON   = 1'b0;
  localparam logic [1:0]  RST_LENGTH_CODE = 2'h0;
  localparam logic        RST_FSM_ON      = 1'b0;

  // PA clock period factors, in DAC clock periods
  localparam logic [7:0] PA_MAIN_FACTOR = 8'h04;
  localparam logic [7:0] PA_CHAN_FACTOR = 8'h08;
  localparam logic [7:0] PA_BYPASS_PER  = 8'h20;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } spd_rd_state_t;

endpackage : spd_pkg

// ===== logic/spd_short_avg.sv
/*
  One datapath's short-window power averager: squares the upper bits of
  I and Q once per PA clock tick, averages over 2^code ticks and flags
  an average above the limit.
  Assumes paTick is a one-cycle pulse and samples are two's complement.
*/
`timescale 1ns/100ps
module spd_short_avg
  import spd_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                detectOn,
  input  wire logic [1:0]          lengthCode,
  input  wire logic                paTick,
  input  wire logic [SAMPLE_W-1:0] sampleI,
  input  wire logic [SAMPLE_W-1:0] sampleQ,
  input  wire logic [12:0]         limit,
  output logic      [12:0]         powerValue,
  output logic                     errorPulse
);
  import spd_pkg::*;

  logic signed [5:0] iTop;
  logic signed [5:0] qTop;
  logic        [11:0] instPower;
  logic        [14:0] accReg;
  logic        [14:0] accSum;
  logic        [2:0]  tickCnt;
  logic        [2:0]  lastTick;
  logic        [12:0] avgNext;

  assign iTop = sampleI[SAMPLE_W-1 -: SAMPLE_MSBS];
  assign qTop = sampleQ[SAMPLE_W-1 -: SAMPLE_MSBS];
  assign instPower = 12'(iTop * iTop) + 12'(qTop * qTop);

  assign accSum   = accReg + 15'(instPower);
  assign lastTick = 3'((4'h1 << lengthCode) - 4'h1);
  assign avgNext  = 13'(accSum >> lengthCode);

  always_ff @(posedge clk_sys) begin
    if (rst || !detectOn) begin
      accReg  <= 15'h0000;
      tickCnt <= 3'h0;
    end else if (paTick) begin
      if (tickCnt == lastTick) begin
        accReg  <= 15'h0000;
        tickCnt <= 3'h0;
      end else begin
        accReg  <= accSum;
        tickCnt <= tickCnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      powerValue <= 13'h0000;
    end else if (detectOn && paTick && tickCnt == lastTick) begin
      powerValue <= avgNext;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      errorPulse <= 1'b0;
    end else begin
      errorPulse <= detectOn && paTick && tickCnt == lastTick
                    && avgNext > limit;
    end
  end

endmodule : spd_short_avg

// ===== logic/spd_power_detector.sv
/*
  Short-window average power detector for NUM_DAC main datapaths, with
  paged control registers, long-window readback, transmit gate FSM
  enables and a level interrupt, all behind an AXI4-Lite slave.
  Assumes clk_sys stands for the DAC clock and samples arrive on it.
*/
// What this block does
// - power is I squared plus Q squared, six MSBs
// - short average readable as 13 bits, two bytes
// - long power bits 12:8 readable, upper reserved
// - writable 13-bit short limit over two bytes
// - control bit 7 enables averaging and detection
// - window lasts two to the code PA periods
// - PA period from main interpolation, 32 when both interpolations bypass; channel interpolation only picks the factor
// - bit 0 enables transmit gate FSM, reset off
// - page select picks which DACs an access hits
// - short error triggers ramp-down when enabled
`timescale 1ns/100ps
module spd_power_detector
  import spd_pkg::*;
#(
  parameter int NUM_DAC  = 2,
  parameter int SAMPLE_W = 16,
  parameter int ADDR_W   = 16
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [NUM_DAC*SAMPLE_W-1:0] sampleI,
  input  wire logic [NUM_DAC*SAMPLE_W-1:0] sampleQ,
  input  wire logic [3:0]                  mainInterp,
  input  wire logic [3:0]                  chanInterp,
  input  wire logic [NUM_DAC*13-1:0]       longWindowPowerValue,
  output logic [NUM_DAC-1:0]               txGateFsmOn,
  output logic [NUM_DAC-1:0]               rampDownReq,
  output logic                             irq
);
  import spd_pkg::*;

  // write channel holding flags
  logic                awHeld_reg;
  logic                wHeld_reg;
  logic [ADDR_W-1:0]   awAddr_reg;
  logic [31:0]         wData_reg;
  logic [3:0]          wStrb_reg;
  logic                bValid_reg;
  logic [1:0]          bResp_reg;
  logic                wrFire;
  logic [11:0]         wrIdx;
  logic                wrLane0;
  logic                wrMapped;

  // read channel
  spd_rd_state_t       rdState_reg;
  logic [31:0]         rData_reg;
  logic [1:0]          rResp_reg;
  logic [11:0]         rdIdx;
  logic [31:0]         rdMux;
  logic                rdMapped;
  logic                rdFire;

  // paged control and status
  logic [1:0]          pageSel_reg;
  logic [12:0]         limit_reg      [NUM_DAC];
  logic                detectOn_reg   [NUM_DAC];
  logic [1:0]          lengthCode_reg [NUM_DAC];
  logic                fsmOn_reg      [NUM_DAC];
  logic                rampOn_reg     [NUM_DAC];
  logic [12:0]         shortPower     [NUM_DAC];
  logic [NUM_DAC-1:0]  shortError;
  logic [NUM_DAC-1:0]  irqStatus_reg;
  logic [NUM_DAC-1:0]  irqEnable_reg;
  logic [NUM_DAC-1:0]  irqClear;
  logic                rdDac;
  logic                rdAny;

  // PA clock tick
  logic [7:0]          paPeriod;
  logic [7:0]          paCnt_reg;
  logic                paTick;

  always_comb begin
    if (mainInterp > 4'h1) begin
      paPeriod = 8'(PA_MAIN_FACTOR * {4'h0, mainInterp});
    end else if (chanInterp > 4'h1) begin
      paPeriod = 8'(PA_CHAN_FACTOR * {4'h0, mainInterp});
    end else begin
      paPeriod = PA_BYPASS_PER;
    end
  end

  assign paTick = (paCnt_reg >= paPeriod - 8'h01);

  always_ff @(posedge clk_sys) begin
    if (rst || paTick) begin
      paCnt_reg <= 8'h00;
    end else begin
      paCnt_reg <= paCnt_reg + 8'h01;
    end
  end

  // one averager per main datapath
  for (genvar g = 0; g < NUM_DAC; g++) begin : gen_dac
    spd_short_avg #(
      .SAMPLE_W (SAMPLE_W)
    ) u_avg (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .detectOn   (detectOn_reg[g]),
      .lengthCode (lengthCode_reg[g]),
      .paTick     (paTick),
      .sampleI    (sampleI[g*SAMPLE_W +: SAMPLE_W]),
      .sampleQ    (sampleQ[g*SAMPLE_W +: SAMPLE_W]),
      .limit      (limit_reg[g]),
      .powerValue (shortPower[g]),
      .errorPulse (shortError[g])
    );
  end

  // AXI write address and data may arrive in either order
  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready  = !wHeld_reg && !bValid_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign wrFire  = awHeld_reg && wHeld_reg && !bValid_reg;
  assign wrIdx   = awAddr_reg[13:2];
  assign wrLane0 = wStrb_reg[0] && wrMapped;

  always_comb begin
    case (wrIdx)
      IDX_PAGE_SELECT, IDX_RAMP_CONTROL, IDX_LONG_POWER_HIGH,
      IDX_SHORT_THR_LOW, IDX_SHORT_THR_HIGH, IDX_SHORT_CONTROL,
      IDX_SHORT_POWER_LOW, IDX_SHORT_POWER_HIGH, IDX_TX_FSM_CONTROL,
      IDX_IRQ_STATUS, IDX_IRQ_CLEAR, IDX_IRQ_ENABLE:
        wrMapped = (awAddr_reg[ADDR_W-1:14] == '0);
      default: wrMapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bValid_reg <= 1'b0;
      bResp_reg  <= RESP_OKAY;
    end else if (wrFire) begin
      bValid_reg <= 1'b1;
      bResp_reg  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_reg <= 1'b0;
    end
  end

  // page select is not itself paged
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pageSel_reg <= RST_PAGE_SELECT;
    end else if (wrFire && wrLane0 && wrIdx == IDX_PAGE_SELECT) begin
      pageSel_reg <= wData_reg[1:0];
    end
  end

  // writes reach only the selected datapaths
  always_ff @(posedge clk_sys) begin
    for (int d = 0; d < NUM_DAC; d++) begin
      if (rst) begin
        limit_reg[d]      <= RST_THRESHOLD;
        detectOn_reg[d]   <= RST_DETECT_ON;
        lengthCode_reg[d] <= RST_LENGTH_CODE;
        fsmOn_reg[d]      <= RST_FSM_ON;
        rampOn_reg[d]     <= RST_RAMP_ON;
      end else if (wrFire && wrLane0 && pageSel_reg[d]) begin
        case (wrIdx)
          IDX_SHORT_THR_LOW: begin
            limit_reg[d][7:0] <= wData_reg[7:0];
          end
          IDX_SHORT_THR_HIGH: begin
            limit_reg[d][12:8] <= wData_reg[HIGH_FIELD_BITS-1:0];
          end
          IDX_SHORT_CONTROL: begin
            detectOn_reg[d]   <= wData_reg[POS_DETECT_ON];
            lengthCode_reg[d] <= wData_reg[1:0];
          end
          IDX_TX_FSM_CONTROL: begin
            fsmOn_reg[d] <= wData_reg[POS_FSM_ON];
          end
          IDX_RAMP_CONTROL: begin
            rampOn_reg[d] <= wData_reg[POS_RAMP_ON];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_comb begin
    for (int d = 0; d < NUM_DAC; d++) begin
      txGateFsmOn[d] = fsmOn_reg[d];
    end
  end

  // error drives ramp-down only when enabled
  always_ff @(posedge clk_sys) begin
    for (int d = 0; d < NUM_DAC; d++) begin
      if (rst) begin
        rampDownReq[d] <= 1'b0;
      end else begin
        rampDownReq[d] <= shortError[d] && rampOn_reg[d];
      end
    end
  end

  // clear register is write-only, one bit per datapath
  assign irqClear = (wrFire && wrLane0 && wrIdx == IDX_IRQ_CLEAR)
                    ? wData_reg[NUM_DAC-1:0] : '0;

  // sticky error; a new event beats a clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqStatus_reg <= '0;
    end else begin
      irqStatus_reg <= (irqStatus_reg & ~irqClear) | shortError;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqEnable_reg <= '0;
    end else if (wrFire && wrLane0 && wrIdx == IDX_IRQ_ENABLE) begin
      irqEnable_reg <= wData_reg[NUM_DAC-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_reg & irqEnable_reg);
    end
  end

  // reads return the lowest selected datapath
  always_comb begin
    rdDac = 1'b0;
    rdAny = 1'b0;
    for (int d = NUM_DAC - 1; d >= 0; d--) begin
      if (pageSel_reg[d]) begin
        rdDac = 1'(d);
        rdAny = 1'b1;
      end
    end
  end

  assign rdIdx = s_axi_araddr[13:2];

  always_comb begin
    rdMux    = 32'h0000_0000;
    rdMapped = (s_axi_araddr[ADDR_W-1:14] == '0);
    case (rdIdx)
      IDX_PAGE_SELECT:    rdMux[1:0] = pageSel_reg;
      IDX_RAMP_CONTROL:   rdMux[POS_RAMP_ON] = rdAny && rampOn_reg[rdDac];
      // long power upper bits, reserved read zero
      IDX_LONG_POWER_HIGH: begin
        if (rdAny) begin
          rdMux[4:0] = longWindowPowerValue[rdDac*13+8 +: 5];
        end
      end
      IDX_SHORT_THR_LOW:  if (rdAny) rdMux[7:0] = limit_reg[rdDac][7:0];
      IDX_SHORT_THR_HIGH: if (rdAny) rdMux[4:0] = limit_reg[rdDac][12:8];
      IDX_SHORT_CONTROL: begin
        if (rdAny) begin
          rdMux[POS_DETECT_ON] = detectOn_reg[rdDac];
          rdMux[1:0]           = lengthCode_reg[rdDac];
        end
      end
      IDX_SHORT_POWER_LOW:  if (rdAny) rdMux[7:0] = shortPower[rdDac][7:0];
      IDX_SHORT_POWER_HIGH: if (rdAny) rdMux[4:0] = shortPower[rdDac][12:8];
      IDX_TX_FSM_CONTROL: rdMux[POS_FSM_ON] = rdAny && fsmOn_reg[rdDac];
      IDX_IRQ_STATUS:     rdMux[NUM_DAC-1:0] = irqStatus_reg;
      IDX_IRQ_CLEAR:      rdMux = 32'h0000_0000;
      IDX_IRQ_ENABLE:     rdMux[NUM_DAC-1:0] = irqEnable_reg;
      default:            rdMapped = 1'b0;
    endcase
  end

  // read data registered; one read in flight
  assign s_axi_arready = (rdState_reg == RD_IDLE);
  assign s_axi_rvalid  = (rdState_reg == RD_DATA);
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;
  assign rdFire        = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdState_reg <= RD_IDLE;
      rData_reg   <= 32'h0000_0000;
      rResp_reg   <= RESP_OKAY;
    end else begin
      case (rdState_reg)
        RD_IDLE: begin
          if (rdFire) begin
            rdState_reg <= RD_DATA;
            rData_reg   <= rdMapped ? rdMux : 32'h0000_0000;
            rResp_reg   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
          end
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            rdState_reg <= RD_IDLE;
          end
        end
        default: begin
          rdState_reg <= RD_IDLE;
        end
      endcase
    end
  end

endmodule : spd_power_detector

// ===== sim/spd_power_detector_monitor.sv
/*
  Timing checker for the short power detector's bus and outputs.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module spd_power_detector_monitor #(
  parameter int NUM_DAC = 2
) (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [NUM_DAC-1:0] txGateFsmOn,
  input wire logic [NUM_DAC-1:0] rampDownReq,
  input wire logic               irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (
    wrTaken |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_resp_held: assert property (
    s_axi_bvalid |=> (s_axi_bvalid == !$past(s_axi_bready))
    && (!s_axi_bvalid || $stable(s_axi_bresp)))
    else $error("write response dropped");
  a_read_answer: assert property (
    rdTaken |=> s_axi_rvalid) else $error("read answer late");
  a_read_held: assert property (
    s_axi_rvalid |=> (s_axi_rvalid == !$past(s_axi_rready))
    && (!s_axi_rvalid || ($stable(s_axi_rdata) && $stable(s_axi_rresp))))
    else $error("read data dropped");
  a_write_blocked: assert property (
    wrTaken |=> !s_axi_awready && !s_axi_wready)
    else $error("second write taken early");
  a_fsm_by_write: assert property (
    !$stable(txGateFsmOn) |-> $rose(s_axi_bvalid))
    else $error("fsm enable moved without write");
  a_ramp_pulse: assert property (
    rampDownReq != '0 |=> rampDownReq == '0) else $error("ramp pulse long");
  a_reset_quiet: assert property (
    $fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq
    && txGateFsmOn == '0 && rampDownReq == '0)
    else $error("outputs busy after reset");
endmodule : spd_power_detector_monitor

// ===== sim/spd_sample_source.sv
/*
  Upstream sample source: holds the six top bits of each I and Q sample
  as set by the bench and churns the low bits every cycle.
  Assumes one sample per datapath per clk_sys cycle.
*/
`timescale 1ns/100ps
module spd_sample_source #(
  parameter int NUM_DAC = 2
) (
  input  wire logic                  clk_sys,
  input  wire logic [NUM_DAC*6-1:0]  topI,
  input  wire logic [NUM_DAC*6-1:0]  topQ,
  output logic      [NUM_DAC*16-1:0] sampleI = '0,
  output logic      [NUM_DAC*16-1:0] sampleQ = '0
);
  integer seed = 32'h5DC34989;
  always @(posedge clk_sys) begin
    for (int d = 0; d < NUM_DAC; d++) begin
      sampleI[d*16 +: 16] <= {topI[d*6 +: 6], 10'($random(seed))};
      sampleQ[d*16 +: 16] <= {topQ[d*6 +: 6], 10'($random(seed))};
    end
  end
endmodule : spd_sample_source

// ===== sim/spd_power_detector_bench.sv
/*
  Self-checking bench of the short power detector: bus tasks note
  expectations in a queue, a watcher compares each bus answer.
  Assumes the sample source model feeds the datapaths.
*/
`timescale 1ns/100ps
module spd_power_detector_bench;
  import spd_pkg::*;
  localparam int NUM_DAC = 2;
  localparam logic [3:0] MI [4] = '{4'h2, 4'h3, 4'h1, 4'h1};
  localparam logic [3:0] CI [4] = '{4'h1, 4'h1, 4'h2, 4'h1};
  localparam int PER [4] = '{8, 12, 8, 32};
  localparam logic [11:0] ZERO_IDX [7] = '{IDX_SHORT_THR_LOW,
    IDX_SHORT_THR_HIGH, IDX_SHORT_CONTROL, IDX_SHORT_POWER_LOW,
    IDX_SHORT_POWER_HIGH, IDX_TX_FSM_CONTROL, IDX_IRQ_STATUS};
  logic clk_sys = 1'b0, rst = 1'b1;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, sampleI, sampleQ;
  logic [3:0] s_axi_wstrb = 4'hF, mainInterp = 4'h2, chanInterp = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, txGateFsmOn, rampDownReq;
  logic [25:0] longWindowPowerValue = '0;
  logic [11:0] topI = '0, topQ = '0;
  logic [33:0] notes [$];
  int num_errors = 0, checked = 0, cycles = 0, ramps = 0;
  integer seed = 32'h5DC34989;

  always #4 clk_sys = ~clk_sys;

  spd_power_detector #(.NUM_DAC(NUM_DAC)) u_spd_power_detector (.*);
  spd_sample_source #(.NUM_DAC(NUM_DAC)) u_spd_sample_source (.*);

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic fail(input string what, input logic [33:0] g, e);
    num_errors++;
    $display("CHECK FAILED %0t %s got %h expected %h", $time, what, g, e);
  endtask : fail

  task automatic cmp_bus(input logic [33:0] got);
    logic [33:0] exp;
    checked++;
    if (notes.size() == 0) fail("unexpected answer", got, 34'h0);
    else begin
      exp = notes.pop_front();
      if (got !== exp) fail("bus answer", got, exp);
    end
  endtask : cmp_bus

  task automatic flag(input logic [2:0] exp);
    @(negedge clk_sys);
    checked++;
    if ({irq, txGateFsmOn} !== exp) fail("flags", {irq, txGateFsmOn}, exp);
    @(posedge clk_sys);
  endtask : flag

  task automatic cmp_ramp(input int base, input logic exp);
    checked++;
    if ((ramps != base) !== exp) fail("ramp", 34'(ramps), 34'(exp));
  endtask : cmp_ramp

  task automatic wr(input logic [11:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic aw, w, ra, rw;
    notes.push_back({er, 32'h0});
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(negedge clk_sys);
      ra = s_axi_awready;
      rw = s_axi_wready;
      @(posedge clk_sys);
      if (aw && ra) begin s_axi_awvalid <= 1'b0; aw = 1'b0; end
      if (w && rw) begin s_axi_wvalid <= 1'b0; w = 1'b0; end
    end
    do begin @(negedge clk_sys); ra = s_axi_bvalid; @(posedge clk_sys); end
    while (!ra);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [11:0] idx, input logic [31:0] ed,
                    input logic [1:0] er);
    logic r;
    notes.push_back({er, ed});
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(negedge clk_sys); r = s_axi_arready; @(posedge clk_sys); end
    while (!r);
    s_axi_arvalid <= 1'b0;
    do begin @(negedge clk_sys); r = s_axi_rvalid; @(posedge clk_sys); end
    while (!r);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  function automatic logic [12:0] pow(input logic [5:0] a, b);
    int x, y;
    x = $signed(a);
    y = $signed(b);
    return 13'(x * x + y * y);
  endfunction : pow

  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) cmp_bus({s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp_bus({s_axi_bresp, 32'h0});
    if (rampDownReq[0]) ramps++;
    cycles++;
    // the whole run needs about 1250 cycles
    if (cycles == 20000) begin num_errors++; wrap_up(); end
  end

  initial begin : main
    logic [25:0] lw;
    logic [12:0] pw, lim;
    logic [5:0] ti, tq;
    int n;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (ZERO_IDX[k]) rd(ZERO_IDX[k], 32'h0, RESP_OKAY);
    rd(IDX_PAGE_SELECT, 32'h1, RESP_OKAY);
    rd(IDX_RAMP_CONTROL, 32'h80, RESP_OKAY);
    rd(12'h100, 32'h0, RESP_SLVERR);
    wr(12'h100, 8'h5A, RESP_SLVERR);
    wr(IDX_SHORT_THR_HIGH, 8'hFF, RESP_OKAY);
    rd(IDX_SHORT_THR_HIGH, 32'h1F, RESP_OKAY);
    wr(IDX_SHORT_CONTROL, 8'h7F, RESP_OKAY);
    rd(IDX_SHORT_CONTROL, 32'h3, RESP_OKAY);
    lw = 26'($random(seed));
    longWindowPowerValue <= lw;
    wr(IDX_TX_FSM_CONTROL, 8'hFF, RESP_OKAY);
    flag(3'b001);
    rd(IDX_TX_FSM_CONTROL, 32'h1, RESP_OKAY);
    wr(IDX_PAGE_SELECT, 8'h2, RESP_OKAY);
    rd(IDX_TX_FSM_CONTROL, 32'h0, RESP_OKAY);
    rd(IDX_LONG_POWER_HIGH, {27'h0, lw[25:21]}, RESP_OKAY);
    wr(IDX_TX_FSM_CONTROL, 8'h1, RESP_OKAY);
    flag(3'b011);
    wr(IDX_PAGE_SELECT, 8'h3, RESP_OKAY);
    rd(IDX_LONG_POWER_HIGH, {27'h0, lw[12:8]}, RESP_OKAY);
    wr(IDX_TX_FSM_CONTROL, 8'h0, RESP_OKAY);
    flag(3'b000);
    s_axi_wstrb <= 4'hE;
    wr(IDX_TX_FSM_CONTROL, 8'h1, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    flag(3'b000);
    wr(IDX_PAGE_SELECT, 8'h1, RESP_OKAY);
    ti = 6'($random(seed)) | 6'h01;
    tq = 6'($random(seed));
    pw = pow(ti, tq);
    topI <= {6'h15, ti};
    topQ <= {6'h2A, tq};
    wr(IDX_SHORT_THR_LOW, 8'hFF, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      mainInterp <= MI[k];
      chanInterp <= CI[k];
      wr(IDX_SHORT_CONTROL, 8'h80 | 8'(k), RESP_OKAY);
      repeat ((1 << k) * PER[k] * 2 + 16) @(posedge clk_sys);
      rd(IDX_SHORT_POWER_LOW, {24'h0, pw[7:0]}, RESP_OKAY);
      rd(IDX_SHORT_POWER_HIGH, {27'h0, pw[12:8]}, RESP_OKAY);
    end
    wr(IDX_SHORT_CONTROL, 8'h00, RESP_OKAY);
    topI <= '0;
    repeat (100) @(posedge clk_sys);
    rd(IDX_SHORT_POWER_LOW, {24'h0, pw[7:0]}, RESP_OKAY);
    topI <= {6'h15, ti};
    lim = pw - 13'h1;
    wr(IDX_SHORT_THR_LOW, lim[7:0], RESP_OKAY);
    wr(IDX_SHORT_THR_HIGH, {3'h0, lim[12:8]}, RESP_OKAY);
    wr(IDX_IRQ_ENABLE, 8'h1, RESP_OKAY);
    n = ramps;
    wr(IDX_SHORT_CONTROL, 8'h80, RESP_OKAY);
    repeat (80) @(posedge clk_sys);
    flag(3'b100);
    rd(IDX_IRQ_STATUS, 32'h1, RESP_OKAY);
    wr(IDX_IRQ_ENABLE, 8'h0, RESP_OKAY);
    flag(3'b000);
    cmp_ramp(n, 1'b1);
    wr(IDX_RAMP_CONTROL, 8'h00, RESP_OKAY);
    n = ramps;
    repeat (80) @(posedge clk_sys);
    cmp_ramp(n, 1'b0);
    wr(IDX_SHORT_CONTROL, 8'h00, RESP_OKAY);
    wr(IDX_IRQ_CLEAR, 8'h1, RESP_OKAY);
    rd(IDX_IRQ_STATUS, 32'h0, RESP_OKAY);
    wr(IDX_IRQ_ENABLE, 8'h1, RESP_OKAY);
    wr(IDX_SHORT_THR_LOW, pw[7:0], RESP_OKAY);
    wr(IDX_SHORT_THR_HIGH, {3'h0, pw[12:8]}, RESP_OKAY);
    wr(IDX_SHORT_CONTROL, 8'h80, RESP_OKAY);
    repeat (80) @(posedge clk_sys);
    flag(3'b000);
    wrap_up();
  end
endmodule : spd_power_detector_bench

bind spd_power_detector spd_power_detector_monitor #(.NUM_DAC(NUM_DAC))
  u_spd_power_detector_monitor (.clk_sys(clk_sys), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .txGateFsmOn(txGateFsmOn),
  .rampDownReq(rampDownReq), .irq(irq));
